/* File: hw/config_status_chain_pins.sv */
// Purpose: configuration status lines, chain enable and serial read control
// Assumes: open-drain lines pulled high outside; i_clk is 40 MHz
// Notes: open-drain pins are a sampled input plus an enable that is low while driving
// How it works
// - the done line is driven low from reset and all through data loading.
// - after every bit arrives without error and init begins, the done line is released.
// - the done line is read back and only when it reads high does init finish into user mode.
// - once in user mode a low done line changes nothing.
// - configuration is taken only while the chain enable input is low, and it gates loading.
// - the chain enable output goes low once this device is configured.
// - in active serial mode the data-out control line shifts the read command to the memory.
// - the status line is held low until power-on reset expires, then released.
// - release of the status line starts a configuration attempt that runs to configured.
// - while power-on reset has not tripped the status line stays driven low.
// - a low request in user mode clears configuration, resets and tri-states io; high restarts.
// - with the request input high, an error in load or a foreign status low in init pulls the status line low.
// - the status line driven low by others during load or init causes an error.
`timescale 1ns/1ps
`default_nettype none
module config_status_chain_pins #(
	parameter int POR_CYCLES = cfg_status_pkg::POR_CYCLES,
	parameter int CFG_BITS = cfg_status_pkg::CFG_BITS,
	parameter int INIT_CYCLES = cfg_status_pkg::INIT_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_active_serial_mode,
	input wire logic i_cfg_request_n,
	input wire logic i_chain_enable_n,
	input wire logic i_data_bit_valid,
	input wire logic i_data_error,
	input wire logic i_status_line,
	output logic o_status_line_oe_n,
	input wire logic i_config_complete_flag,
	output logic o_config_complete_flag_oe_n,
	output logic o_chain_enable_n,
	output logic o_serial_cfg_data_out,
	output logic o_user_mode,
	output logic o_io_tristate
);
	// ----------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync;
	logic reset_n;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign reset_n = rst_sync[1];

	// two stages per outside pin; only stage two is read
	localparam int NPIN = 6;
	// idle levels: all pins high except the error pin, so reset shows no false error
	localparam logic [NPIN-1:0] PIN_IDLE = 6'h3e;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1;
	logic [NPIN-1:0] pin_s2;
	assign pin_raw = {i_active_serial_mode, i_cfg_request_n, i_chain_enable_n,
		i_status_line, i_config_complete_flag, i_data_error};
	always_ff @(posedge i_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
		end else if (i_clk_en) begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end
	logic as_mode;
	logic req_n;
	logic ce_n;
	logic status_in;
	logic done_in;
	logic err_in;
	assign {as_mode, req_n, ce_n, status_in, done_in, err_in} = pin_s2;
	logic err_pin_prev;

	// counter end points, cut to the counter width on purpose
	localparam int CW = cfg_status_pkg::CNT_W;
	localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);
	localparam logic [CW-1:0] LOAD_END = CW'(CFG_BITS);
	localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYCLES - 1);
	localparam logic [3:0] CMD_END = 4'(cfg_status_pkg::CMD_BITS);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		cfg_status_pkg::phase_type phase;
		logic [cfg_status_pkg::CNT_W-1:0] count;
		logic [3:0] cmd_idx;
		logic status_drive;
		logic done_drive;
		logic chain_n;
		logic sdo;
		logic err_seen;
	} state_type;
	state_type st;
	state_type next_st;

	// error source: data error pin (already sampled) or the status line pulled
	// low by someone else while we are not driving it
	function automatic logic foreign_low(input logic drv, input logic line);
		foreign_low = !drv && !line;
	endfunction : foreign_low

	// next-state logic
	always_comb begin
		next_st = st;
		next_st.sdo = 1'b1;
		unique case (st.phase)
			cfg_status_pkg::ST_POR: begin
				next_st.status_drive = 1'b1;
				next_st.done_drive = 1'b1;
				next_st.chain_n = 1'b1;
				if (st.count >= POR_LAST) begin
					next_st.status_drive = 1'b0;
					next_st.count = '0;
					next_st.phase = cfg_status_pkg::ST_WAIT_REQ;
				end else begin
					next_st.count = st.count + 1'b1;
				end
			end
			cfg_status_pkg::ST_WAIT_REQ: begin
				next_st.done_drive = 1'b1;
				next_st.count = '0;
				next_st.cmd_idx = '0;
				// start only with request high, status released high, enable low
				if (req_n && status_in && !ce_n) begin
					next_st.phase = cfg_status_pkg::ST_LOAD;
					next_st.err_seen = 1'b0;
				end
			end
			cfg_status_pkg::ST_LOAD: begin
				next_st.done_drive = 1'b1;
				if (as_mode && st.cmd_idx < CMD_END) begin
					// shift out the read command, msb first
					next_st.sdo = cfg_status_pkg::READ_CMD[3'(7 - st.cmd_idx)];
					next_st.cmd_idx = st.cmd_idx + 1'b1;
				end else if (i_data_bit_valid && !ce_n) begin
					next_st.count = st.count + 1'b1;
				end
				if (err_pin_prev || foreign_low(st.status_drive, status_in)) begin
					next_st.phase = cfg_status_pkg::ST_ERROR;
				end else if (!req_n) begin
					next_st.phase = cfg_status_pkg::ST_WAIT_REQ;
				end else if (st.count >= LOAD_END) begin
					next_st.done_drive = 1'b0;
					next_st.count = '0;
					next_st.phase = cfg_status_pkg::ST_INIT;
				end
			end
			cfg_status_pkg::ST_INIT: begin
				next_st.done_drive = 1'b0;
				if (foreign_low(st.status_drive, status_in)) begin
					next_st.phase = cfg_status_pkg::ST_ERROR;
				end else if (!req_n) begin
					next_st.phase = cfg_status_pkg::ST_WAIT_REQ;
					next_st.done_drive = 1'b1;
				end else if (done_in) begin
					if (st.count >= INIT_LAST) begin
						next_st.phase = cfg_status_pkg::ST_USER;
						next_st.chain_n = 1'b0;
					end else begin
						next_st.count = st.count + 1'b1;
					end
				end
			end
			cfg_status_pkg::ST_USER: begin
				// done and status lines are ignored here
				next_st.done_drive = 1'b0;
				if (!req_n) begin
					next_st.phase = cfg_status_pkg::ST_WAIT_REQ;
					next_st.chain_n = 1'b1;
					next_st.done_drive = 1'b1;
					next_st.count = '0;
				end
			end
			cfg_status_pkg::ST_ERROR: begin
				next_st.status_drive = 1'b1;
				next_st.err_seen = 1'b1;
				next_st.done_drive = 1'b1;
				next_st.chain_n = 1'b1;
				// a fresh request pulse clears the error
				if (!req_n) begin
					next_st.status_drive = 1'b0;
					next_st.phase = cfg_status_pkg::ST_WAIT_REQ;
				end
			end
			default: begin
				next_st.phase = cfg_status_pkg::ST_POR;
			end
		endcase
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge i_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '{phase: cfg_status_pkg::ST_POR, count: '0, cmd_idx: '0,
				status_drive: 1'b1, done_drive: 1'b1, chain_n: 1'b1, sdo: 1'b1,
				err_seen: 1'b0};
			err_pin_prev <= 1'b0;
		end else if (i_clk_en) begin
			st <= next_st;
			err_pin_prev <= err_in;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_status_line_oe_n = !st.status_drive;
	assign o_config_complete_flag_oe_n = !st.done_drive;
	assign o_chain_enable_n = st.chain_n;
	assign o_serial_cfg_data_out = st.sdo;
	assign o_user_mode = (st.phase == cfg_status_pkg::ST_USER);
	assign o_io_tristate = (st.phase != cfg_status_pkg::ST_USER);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_load_phase;
		st.phase == cfg_status_pkg::ST_LOAD;
	endsequence
	sequence s_user_entry;
		$rose(st.phase == cfg_status_pkg::ST_USER);
	endsequence
	sequence s_por_last;
		st.phase == cfg_status_pkg::ST_POR && st.count == POR_LAST && i_clk_en;
	endsequence
	sequence s_start_ready;
		st.phase == cfg_status_pkg::ST_WAIT_REQ && req_n && status_in && !ce_n && i_clk_en;
	endsequence

	// power-on hold ends in the wait phase with the status line let go
	a_por_exit_wait: assert property (@(posedge i_clk) disable iff (!reset_n)
		s_por_last |=> (st.phase == cfg_status_pkg::ST_WAIT_REQ && o_status_line_oe_n))
		else $error("power-on hold did not end cleanly");
	// a released status line with enable low starts a load
	a_start_load_ready: assert property (@(posedge i_clk) disable iff (!reset_n)
		s_start_ready |=> (st.phase == cfg_status_pkg::ST_LOAD))
		else $error("load not started when allowed");
	// chain enable high keeps the block waiting
	a_wait_chain_high: assert property (@(posedge i_clk) disable iff (!reset_n)
		(st.phase == cfg_status_pkg::ST_WAIT_REQ && ce_n && i_clk_en)
		|=> (st.phase == cfg_status_pkg::ST_WAIT_REQ))
		else $error("left wait with chain enable high");
	// done line held low while waiting for a load
	a_done_low_wait: assert property (@(posedge i_clk) disable iff (!reset_n)
		(st.phase == cfg_status_pkg::ST_WAIT_REQ) |-> !o_config_complete_flag_oe_n)
		else $error("done line released before load");
	// status pulled low by others during load or init is an error
	a_foreign_status_err: assert property (@(posedge i_clk) disable iff (!reset_n)
		((st.phase == cfg_status_pkg::ST_LOAD || st.phase == cfg_status_pkg::ST_INIT)
		&& !st.status_drive && !status_in && i_clk_en)
		|=> (st.phase == cfg_status_pkg::ST_ERROR))
		else $error("foreign status low not taken as error");
	// the error record only lives in the error and wait phases
	a_error_flag_kept: assert property (@(posedge i_clk) disable iff (!reset_n)
		st.err_seen |-> (st.phase == cfg_status_pkg::ST_ERROR
		|| st.phase == cfg_status_pkg::ST_WAIT_REQ))
		else $error("error record outside error handling");
	// first command bit is the msb of the read command
	a_cmd_first_bit: assert property (@(posedge i_clk) disable iff (!reset_n)
		(st.phase == cfg_status_pkg::ST_LOAD && as_mode && st.cmd_idx == '0 && i_clk_en)
		|=> (o_serial_cfg_data_out == cfg_status_pkg::READ_CMD[cfg_status_pkg::CMD_BITS - 1]))
		else $error("wrong first command bit");
	// data-out line idles high outside the command shift
	a_sdo_idle_high: assert property (@(posedge i_clk) disable iff (!reset_n)
		(!(st.phase == cfg_status_pkg::ST_LOAD && as_mode) && i_clk_en)
		|=> o_serial_cfg_data_out)
		else $error("data-out line not idle");


	a_done_low_load: assert property (@(posedge i_clk) disable iff (!reset_n)
		s_load_phase |-> !o_config_complete_flag_oe_n)
		else $error("done line released during load");
	a_done_released_init: assert property (@(posedge i_clk) disable iff (!reset_n)
		(st.phase == cfg_status_pkg::ST_INIT) |-> o_config_complete_flag_oe_n)
		else $error("done line driven during init");
	a_user_needs_done: assert property (@(posedge i_clk) disable iff (!reset_n)
		s_user_entry |-> $past(done_in))
		else $error("user mode without done high");
	a_user_ignores_done: assert property (@(posedge i_clk) disable iff (!reset_n)
		(o_user_mode && req_n && i_clk_en) |=> o_user_mode)
		else $error("user mode left without request");
	a_load_needs_ce: assert property (@(posedge i_clk) disable iff (!reset_n)
		$rose(st.phase == cfg_status_pkg::ST_LOAD) |-> $past(!ce_n))
		else $error("load began with chain enable high");
	a_chain_out_user: assert property (@(posedge i_clk) disable iff (!reset_n)
		o_chain_enable_n == !o_user_mode)
		else $error("chain enable out mismatch");
	a_status_held_por: assert property (@(posedge i_clk) disable iff (!reset_n)
		(st.phase == cfg_status_pkg::ST_POR) |-> !o_status_line_oe_n)
		else $error("status released before por end");
	a_error_drives_status: assert property (@(posedge i_clk) disable iff (!reset_n)
		(st.phase == cfg_status_pkg::ST_ERROR && req_n && i_clk_en) |=> !o_status_line_oe_n)
		else $error("error not reported");
	a_request_resets: assert property (@(posedge i_clk) disable iff (!reset_n)
		(o_user_mode && !req_n && i_clk_en) |=> o_io_tristate)
		else $error("request low did not leave user mode");
endmodule : config_status_chain_pins
`default_nettype wire

/* File: hw/cfg_status_pkg.sv */
// Purpose: shared constants for the configuration status and chain block
// Assumes: 40 MHz system clock
// Notes: timing figures kept in their own unit, cycle counts derived
package cfg_status_pkg;
	localparam int CLK_MHZ = 40;
	// power-on reset hold time, microseconds
	localparam int POR_TIME_US = 12;
	localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
	// bits of configuration data expected per image
	localparam int CFG_BITS = 1024;
	// initialization cycles after the done line reads high
	localparam int INIT_CYCLES = 16;
	localparam int CNT_W = 16;
	// serial read command shifted out to the memory, msb first
	localparam logic [7:0] READ_CMD = 8'h03;
	localparam int CMD_BITS = 8;
	typedef enum logic [2:0] {
		ST_POR,
		ST_WAIT_REQ,
		ST_LOAD,
		ST_INIT,
		ST_USER,
		ST_ERROR
	} phase_type;
endpackage : cfg_status_pkg

/* File: tb/cfg_line_model.sv */
// Purpose: pull-ups and outside drivers on the two open-drain lines
// Assumes: both lines carry a pull-up
// Notes: a line reads low whenever any party pulls it
`timescale 1ns/1ps
`default_nettype none
module cfg_line_model (
	input wire logic i_status_oe_n,
	input wire logic i_done_oe_n,
	input wire logic i_ext_status_low,
	input wire logic i_ext_done_low,
	output logic o_status_line,
	output logic o_done_line
);
	// wired-and of device and outside drivers, pull-up otherwise
	assign o_status_line = i_status_oe_n & ~i_ext_status_low;
	assign o_done_line = i_done_oe_n & ~i_ext_done_low;
endmodule : cfg_line_model
`default_nettype wire

/* File: tb/config_status_chain_pins_tb_top.sv */
// Purpose: random and corner runs of the status and chain block
// Assumes: 25 ns clock, shortened counts
// Notes: open-drain lines resolved by cfg_line_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin \
	$display("unexpected %0t %s", $time, m); n_errors++; end end
module config_status_chain_pins_tb_top;
	localparam int NBITS = 16;
	logic clk = 0, rst_n = 0, as_mode = 1, req_n = 1, ce_n = 0, bit_v = 0, err = 0;
	logic ext_st = 0, ext_dn = 0, st_line, dn_line, st_oe_n, dn_oe_n, chain_n, sdo, user, tri_io;
	int n_errors = 0, n_compared = 0, seed = 32'h27b8;
	logic saw_low = 0;
	always #12.5 clk = ~clk;
	// read command holds zeros, so the data-out line must dip
	always @(posedge clk) if (sdo === 1'b0) saw_low <= 1'b1;
	cfg_line_model lines (.i_status_oe_n(st_oe_n), .i_done_oe_n(dn_oe_n),
		.i_ext_status_low(ext_st), .i_ext_done_low(ext_dn),
		.o_status_line(st_line), .o_done_line(dn_line));
	// chain output watched only, feeds nothing
	config_status_chain_pins #(.POR_CYCLES(4), .CFG_BITS(NBITS), .INIT_CYCLES(2)) dut (
		.i_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .i_active_serial_mode(as_mode),
		.i_cfg_request_n(req_n), .i_chain_enable_n(ce_n), .i_data_bit_valid(bit_v),
		.i_data_error(err), .i_status_line(st_line), .o_status_line_oe_n(st_oe_n),
		.i_config_complete_flag(dn_line), .o_config_complete_flag_oe_n(dn_oe_n),
		.o_chain_enable_n(chain_n), .o_serial_cfg_data_out(sdo), .o_user_mode(user),
		.o_io_tristate(tri_io));
	task automatic print_verdict;
		if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	function automatic logic pick(input int k);
		case (k)
			0: return st_oe_n;
			1: return dn_oe_n;
			default: return user;
		endcase
	endfunction : pick
	// bounded wait for one output to reach a level
	task automatic wait_for(input int k, input logic v);
		for (int i = 0; i < 300 && pick(k) !== v; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK(pick(k), v, "wait ran out")
		if (pick(k) !== v) print_verdict();
	endtask : wait_for
	// one-cycle bit pulses with random gaps
	task automatic send_bits(input int n);
		for (int i = 0; i < n; i++) begin
			repeat ($unsigned($random(seed)) % 3) @(posedge clk);
			@(posedge clk) bit_v <= 1'b1;
			@(posedge clk) bit_v <= 1'b0;
			#1;
			if (i < n - 1) `CHK(dn_oe_n, 1'b0, "done released early")
		end
	endtask : send_bits
	// chain enable low from time zero, as at the head of a chain; raised once to check that loading is blocked
	initial begin
		repeat (4) @(posedge clk);
		#1;
		`CHK(st_oe_n, 1'b0, "status free in reset")
		`CHK(chain_n, 1'b1, "chain low in reset")
		@(posedge clk) rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK(st_oe_n, 1'b0, "status freed before por")
		wait_for(0, 1'b1);
		ext_dn <= 1'b1;
		repeat (12) @(posedge clk);
		send_bits(NBITS);
		wait_for(1, 1'b1);
		`CHK(saw_low, 1'b1, "no read command")
		repeat (10) @(posedge clk);
		#1;
		`CHK(user, 1'b0, "user mode with done low")
		ext_dn <= 1'b0;
		wait_for(2, 1'b1);
		`CHK(chain_n, 1'b0, "chain not handed on")
		`CHK(tri_io, 1'b0, "io still off")
		ext_dn <= 1'b1;
		ext_st <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		`CHK(user, 1'b1, "user mode lost")
		`CHK(st_oe_n, 1'b1, "status pulled in user mode")
		ext_dn <= 1'b0;
		ext_st <= 1'b0;
		req_n <= 1'b0;
		wait_for(2, 1'b0);
		`CHK(tri_io, 1'b1, "io not off")
		ce_n <= 1'b1;
		req_n <= 1'b1;
		repeat (12) @(posedge clk);
		send_bits(NBITS);
		repeat (6) @(posedge clk);
		#1;
		`CHK(dn_oe_n, 1'b0, "loaded while disabled")
		ce_n <= 1'b0;
		repeat (12) @(posedge clk);
		send_bits(NBITS / 2);
		err <= 1'b1;
		wait_for(0, 1'b0);
		err <= 1'b0;
		req_n <= 1'b0;
		repeat (4) @(posedge clk);
		req_n <= 1'b1;
		as_mode <= 1'b0;
		wait_for(0, 1'b1);
		ext_dn <= 1'b1;
		repeat (12) @(posedge clk);
		send_bits(NBITS);
		wait_for(1, 1'b1);
		ext_st <= 1'b1;
		wait_for(0, 1'b0);
		ext_dn <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
		`CHK(user, 1'b0, "error left for user mode")
		print_verdict();
	end
endmodule : config_status_chain_pins_tb_top
`default_nettype wire
